// File: rtl/quasi_port.sv
// quasi-bidirectional 8-bit port with alternate functions and reset pin
// assumes pin inputs synchronous to clk; pin level resolved by the bench

// What this block does
// - reset sets latch ones; rst_b gives weak pullup only, core_reset gives bits that held zero a boost pulse first
// - written zero turns strong pulldown on
// - zero-to-one write gives short strong pull-high
// - bits zero-three feed interrupts or capture triggers
// - capture enable routes pins to capture triggers
// - bit four timer io, five reload trigger
// - bit six serial receive, seven transmit
// - reset pin is active-high, wire-ored request
// - internal reset sources drive reset pin out
// - pin high whole internal reset plus a four-cycle hold, then low
module quasi_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic latch_write,
  input wire logic [7:0] latch_wdata,
  output logic [7:0] latch_rdata,
  output logic [7:0] pin_rdata,
  input wire logic [7:0] quasi_port_pins_in,
  output logic [7:0] quasi_port_pins_out,
  output logic [7:0] quasi_port_pins_oe,
  output quasi_port_pkg::pin_drive_t pin_drive,
  input wire logic capture_enable,
  input wire logic timer_two_io_enable,
  input wire logic timer_two_out,
  input wire logic serial_b_enable,
  input wire logic serial_b_transmit,
  output quasi_port_pkg::alt_inputs_t alt_in,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic watchdog_reset,
  input wire logic power_fail_reset,
  input wire logic crystal_fail_reset,
  output logic core_reset
);
  logic [7:0] latch_reg;
  logic [7:0] latch_next;
  logic [7:0] pin_reg;
  logic [7:0] pin_next;
  logic [7:0] eff_bit;
  logic [7:0] drv_low;
  logic [7:0] drv_high;
  logic [7:0] drv_weak;
  quasi_port_pkg::alt_inputs_t alt_reg;
  quasi_port_pkg::alt_inputs_t alt_next;
  quasi_port_pkg::reset_state_t rst_state_reg;
  quasi_port_pkg::reset_state_t rst_state_next;
  logic [3:0] hold_reg;
  logic [3:0] hold_next;
  logic ext_reset_reg;
  logic ext_reset_next;
  logic internal_src;

  // port latch
  always_comb begin
    latch_next = latch_reg;
    if (latch_write) begin
      latch_next = latch_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || core_reset) begin
      latch_reg <= quasi_port_pkg::latch_reset_value;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // alternate outputs ride the latch: a one in the latch lets them through
  always_comb begin
    eff_bit = latch_reg;
    if (timer_two_io_enable) begin
      eff_bit[quasi_port_pkg::bit_timer_io] =
        latch_reg[quasi_port_pkg::bit_timer_io] & timer_two_out;
    end
    if (serial_b_enable) begin
      eff_bit[quasi_port_pkg::bit_serial_tx] =
        latch_reg[quasi_port_pkg::bit_serial_tx] & serial_b_transmit;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_bit
    quasi_bit_driver u_drv (
      .clk(clk),
      .rst_b(rst_b),
      .latch_bit(eff_bit[i]),
      .drive_low(drv_low[i]),
      .drive_high_strong(drv_high[i]),
      .pull_weak(drv_weak[i])
    );
  end

  // weak pullup is not a drive: the bench resolves it; outside wins
  assign quasi_port_pins_out = drv_high;
  assign quasi_port_pins_oe = drv_low | drv_high;
  assign pin_drive.drive_low = drv_low;
  assign pin_drive.drive_high_strong = drv_high;
  assign pin_drive.pull_weak = drv_weak;

  // pin sampling and alternate inputs
  always_comb begin
    pin_next = quasi_port_pins_in;
    alt_next.ext_irq = quasi_port_pins_in[3:0];
    alt_next.capture_trig = capture_enable ?
      quasi_port_pins_in[3:0] : 4'hf;
    alt_next.timer_two_ext_io =
      quasi_port_pins_in[quasi_port_pkg::bit_timer_io];
    alt_next.timer_two_reload_trigger =
      quasi_port_pins_in[quasi_port_pkg::bit_reload_trig];
    alt_next.serial_b_receive = serial_b_enable ?
      quasi_port_pins_in[quasi_port_pkg::bit_serial_rx] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_reg <= 8'hff;
      alt_reg <= '1;
    end else begin
      pin_reg <= pin_next;
      alt_reg <= alt_next;
    end
  end

  assign pin_rdata = pin_reg;
  assign latch_rdata = latch_reg;
  assign alt_in = alt_reg;

  // reset pin: external request and internal sources
  assign internal_src = watchdog_reset | power_fail_reset | crystal_fail_reset;

  always_comb begin
    rst_state_next = rst_state_reg;
    hold_next = hold_reg;
    // our own drive reads back high; only outside highs count as external
    ext_reset_next = reset_pin_in && !reset_pin_oe;
    case (rst_state_reg)
      quasi_port_pkg::rst_idle: begin
        if (internal_src) begin
          rst_state_next = quasi_port_pkg::rst_internal;
        end
      end
      quasi_port_pkg::rst_internal: begin
        hold_next = quasi_port_pkg::int_reset_hold_load;
        if (!internal_src) begin
          rst_state_next = quasi_port_pkg::rst_release;
        end
      end
      quasi_port_pkg::rst_release: begin
        if (internal_src) begin
          rst_state_next = quasi_port_pkg::rst_internal;
        end else if (hold_reg == 4'h1) begin
          rst_state_next = quasi_port_pkg::rst_idle;
          hold_next = 4'h0;
        end else begin
          hold_next = hold_reg - 4'h1;
        end
      end
      default: begin
        rst_state_next = quasi_port_pkg::rst_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rst_state_reg <= quasi_port_pkg::rst_idle;
      hold_reg <= 4'h0;
      ext_reset_reg <= 1'b0;
    end else begin
      rst_state_reg <= rst_state_next;
      hold_reg <= hold_next;
      ext_reset_reg <= ext_reset_next;
    end
  end

  assign reset_pin_oe = (rst_state_reg != quasi_port_pkg::rst_idle);
  assign reset_pin_out = reset_pin_oe;
  assign core_reset = reset_pin_oe | ext_reset_reg;
endmodule // quasi_port

// File: rtl/quasi_port_pkg.sv
// package for the quasi-bidirectional port and its reset pin
// assumes one 25 MHz core clock and a synchronous active-low reset
package quasi_port_pkg;
  localparam int unsigned port_width = 8;
  localparam logic [7:0] latch_reset_value = 8'hff;
  localparam int unsigned clk_period_ns = 40;
  // strong pull-high pulse, least time
  localparam int unsigned boost_time_ns = 40;
  localparam int unsigned boost_cycles_raw =
    (boost_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned boost_cycles =
    (boost_cycles_raw < 1) ? 1 : boost_cycles_raw;
  localparam logic [3:0] boost_count_load = 4'(boost_cycles);
  localparam logic [3:0] boost_count_zero = 4'h0;
  // internal reset hold after the last internal source drops
  localparam int unsigned int_reset_hold_cycles = 4;
  localparam logic [3:0] int_reset_hold_load = 4'(int_reset_hold_cycles);
  // pin positions of the alternate functions
  localparam int unsigned bit_timer_io = 4;
  localparam int unsigned bit_reload_trig = 5;
  localparam int unsigned bit_serial_rx = 6;
  localparam int unsigned bit_serial_tx = 7;

  typedef struct packed {
    logic [7:0] drive_low;
    logic [7:0] drive_high_strong;
    logic [7:0] pull_weak;
  } pin_drive_t;

  typedef struct packed {
    logic [3:0] ext_irq;
    logic [3:0] capture_trig;
    logic timer_two_ext_io;
    logic timer_two_reload_trigger;
    logic serial_b_receive;
  } alt_inputs_t;

  typedef enum logic [1:0] {
    rst_idle,
    rst_internal,
    rst_release
  } reset_state_t;
endpackage

// File: rtl/quasi_bit_driver.sv
// one quasi-bidirectional pin driver: pulldown, boost pulse, weak pullup
// assumes the latch value arrives registered from the parent
module quasi_bit_driver (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic latch_bit,
  output logic drive_low,
  output logic drive_high_strong,
  output logic pull_weak
);
  logic prev_reg;
  logic prev_next;
  logic [3:0] boost_reg;
  logic [3:0] boost_next;

  always_comb begin
    prev_next = latch_bit;
    boost_next = boost_reg;
    if (!latch_bit) begin
      boost_next = quasi_port_pkg::boost_count_zero;
    end else if (!prev_reg) begin
      boost_next = quasi_port_pkg::boost_count_load;
    end else if (boost_reg != quasi_port_pkg::boost_count_zero) begin
      boost_next = boost_reg - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_reg <= 1'b1;
      boost_reg <= quasi_port_pkg::boost_count_zero;
    end else begin
      prev_reg <= prev_next;
      boost_reg <= boost_next;
    end
  end

  // boost also covers the cycle the one is first seen, so no gap to low
  assign drive_low = !latch_bit;
  assign drive_high_strong = latch_bit &&
    (!prev_reg || boost_reg != quasi_port_pkg::boost_count_zero);
  assign pull_weak = latch_bit;
endmodule // quasi_bit_driver

// File: dv/port_chk_properties.sv
// assertions on the quasi port and its reset pin
// assumes one clock domain; bound into every quasi_port
module port_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic latch_write,
  input wire logic [7:0] latch_wdata,
  input wire logic [7:0] latch_rdata,
  input wire logic [7:0] pin_rdata,
  input wire logic [7:0] quasi_port_pins_in,
  input wire logic [7:0] quasi_port_pins_out,
  input wire logic [7:0] quasi_port_pins_oe,
  input wire quasi_port_pkg::pin_drive_t pin_drive,
  input wire logic capture_enable,
  input wire quasi_port_pkg::alt_inputs_t alt_in,
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe,
  input wire logic watchdog_reset,
  input wire logic power_fail_reset,
  input wire logic crystal_fail_reset,
  input wire logic core_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic src;
  assign src = watchdog_reset | power_fail_reset | crystal_fail_reset;
  property p_rst;
    $rose(rst_b) |-> latch_rdata == 8'hff && pin_drive.pull_weak == 8'hff
      && quasi_port_pins_oe == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
  property p_boost;
    latch_write && latch_wdata[0] && !latch_rdata[0] && !core_reset |=>
      (quasi_port_pins_oe[0] && quasi_port_pins_out[0]) [*2]
      ##1 !quasi_port_pins_oe[0];
  endproperty
  a_boost: assert property (p_boost)
    else $error("pull-high pulse wrong");
  property p_low;
    pin_drive.drive_low[3:0] == ~latch_rdata[3:0];
  endproperty
  a_low: assert property (p_low)
    else $error("pulldown not tied to latch");
  property p_alt;
    alt_in.ext_irq == $past(quasi_port_pins_in[3:0]) &&
      alt_in.timer_two_reload_trigger == $past(quasi_port_pins_in[5]);
  endproperty
  a_alt: assert property (p_alt)
    else $error("alternate input wrong");
  property p_cap;
    $past(capture_enable) |->
      alt_in.capture_trig == $past(quasi_port_pins_in[3:0]);
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture trigger wrong");
  property p_int;
    src |=> reset_pin_oe && reset_pin_in;
  endproperty
  a_int: assert property (p_int)
    else $error("reset pin not driven");
  property p_hold;
    $fell(src) |-> reset_pin_oe [*4] ##[1:4] !reset_pin_oe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset pin release wrong");
  property p_ext;
    reset_pin_in && !reset_pin_oe |=> core_reset;
  endproperty
  a_ext: assert property (p_ext)
    else $error("outside reset ignored");
  // a level held four samples must have reached the read path
  property p_pin;
    $stable(quasi_port_pins_in) [*3] |-> pin_rdata == quasi_port_pins_in;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin read wrong");
endmodule // port_chk
bind quasi_port port_chk i_chk (.*);

// File: dv/pin_world.sv
// outside circuits on the port pins and the reset pin
// assumes weak pullups on the port and a pulldown on the reset pin
module pin_world (
  input wire logic [7:0] quasi_port_pins_out,
  input wire logic [7:0] quasi_port_pins_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  input wire logic ext_rst,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  output logic [7:0] quasi_port_pins_in,
  output logic reset_pin_in
);
  // strong drive wins; an outside driver beats the weak pullup
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (quasi_port_pins_oe[i])
        quasi_port_pins_in[i] = quasi_port_pins_out[i];
      else if (ext_en[i])
        quasi_port_pins_in[i] = ext_val[i];
      else
        quasi_port_pins_in[i] = 1'h1;
    end
  end
  assign reset_pin_in = (reset_pin_oe & reset_pin_out) | ext_rst;
endmodule // pin_world

// File: dv/tb.sv
// self-checking bench for the quasi port and reset pin
// assumes quasi_port, port_chk and pin_world compiled before it
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_b = 1'h0, latch_write = 1'h0, capture_enable = 1'h0;
  logic timer_two_io_enable = 1'h0, timer_two_out = 1'h0;
  logic serial_b_enable = 1'h0, serial_b_transmit = 1'h1, ext_rst = 1'h0;
  logic watchdog_reset = 1'h0, power_fail_reset = 1'h0;
  logic crystal_fail_reset = 1'h0, reset_pin_in, reset_pin_out;
  logic reset_pin_oe, core_reset;
  logic [7:0] latch_wdata = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [7:0] latch_rdata, pin_rdata, quasi_port_pins_in;
  logic [7:0] quasi_port_pins_out, quasi_port_pins_oe;
  quasi_port_pkg::pin_drive_t pin_drive;
  quasi_port_pkg::alt_inputs_t alt_in;
  int bad_count = 0, n_checks = 0;
  quasi_port i_dut (.*);
  pin_world i_pw (.*);
  always #20 clk = ~clk;
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic wr(logic [7:0] d);
    @(negedge clk);
    latch_write = 1'h1;
    latch_wdata = d;
    @(negedge clk);
    latch_write = 1'h0;
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic t_drive;
    chk("latch", 8'hff, latch_rdata);
    chk("weak", 8'hff, pin_drive.pull_weak);
    wr(8'h00);
    repeat (3) @(negedge clk);
    chk("low", 8'hff, pin_drive.drive_low);
    chk("pins", 8'h00, quasi_port_pins_in);
    wr(8'hff);
    chk("boost", 8'hff, quasi_port_pins_oe & quasi_port_pins_out);
    @(negedge clk);
    chk("boost", 8'hff, pin_drive.drive_high_strong);
    @(negedge clk);
    chk("oe", 8'h00, quasi_port_pins_oe);
    chk("pins", 8'hff, quasi_port_pins_in);
  endtask
  task automatic t_alt;
    ext_en = 8'h7f;
    ext_val = 8'h25;
    repeat (4) @(negedge clk);
    chk("read", 8'ha5, pin_rdata);
    chk("irq", 8'h05, {4'h0, alt_in.ext_irq});
    chk("trig", 8'h0f, {4'h0, alt_in.capture_trig});
    chk("reload", 8'h01, {7'h0, alt_in.timer_two_reload_trigger});
    chk("t2_in", 8'h00, {7'h0, alt_in.timer_two_ext_io});
    capture_enable = 1'h1;
    serial_b_enable = 1'h1;
    serial_b_transmit = 1'h0;
    repeat (3) @(negedge clk);
    chk("trig", 8'h05, {4'h0, alt_in.capture_trig});
    chk("rx", 8'h00, {7'h0, alt_in.serial_b_receive});
    chk("tx", 8'h00, {7'h0, quasi_port_pins_in[7]});
    ext_en = 8'h00;
    capture_enable = 1'h0;
    serial_b_enable = 1'h0;
    serial_b_transmit = 1'h1;
    // timer output rides the latch one of bit four
    timer_two_io_enable = 1'h1;
    timer_two_out = 1'h0;
    repeat (2) @(negedge clk);
    chk("t2_out", 8'h00, {7'h0, quasi_port_pins_in[4]});
    timer_two_out = 1'h1;
    repeat (4) @(negedge clk);
    chk("t2_out", 8'h01, {7'h0, quasi_port_pins_in[4]});
    chk("t2_in", 8'h01, {7'h0, alt_in.timer_two_ext_io});
    timer_two_io_enable = 1'h0;
    timer_two_out = 1'h0;
  endtask
  task automatic t_int;
    for (int k = 0; k < 3; k++) begin
      wr(8'h00);
      {crystal_fail_reset, power_fail_reset, watchdog_reset} = 3'h1 << k;
      repeat (2) @(negedge clk);
      chk("rst_pin", 8'h01, {7'h0, reset_pin_in});
      chk("latch", 8'hff, latch_rdata);
      {crystal_fail_reset, power_fail_reset, watchdog_reset} = 3'h0;
      repeat (4) @(negedge clk);
      chk("hold", 8'h01, {7'h0, reset_pin_oe});
      repeat (4) @(negedge clk);
      chk("release", 8'h00, {7'h0, reset_pin_in});
    end
  endtask
  // a write while the core is held in reset must be lost
  task automatic t_ext;
    ext_rst = 1'h1;
    wr(8'h00);
    chk("core", 8'h01, {7'h0, core_reset});
    chk("rst_oe", 8'h00, {7'h0, reset_pin_oe});
    chk("latch", 8'hff, latch_rdata);
    ext_rst = 1'h0;
    repeat (3) @(negedge clk);
    chk("core", 8'h00, {7'h0, core_reset});
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'h1;
    @(negedge clk);
    t_drive();
    t_alt();
    t_int();
    t_ext();
    stop_test();
  end
  // the run needs under 150 cycles; 400 leaves margin for slow releases
  initial begin
    #16000;
    bad_count++;
    stop_test();
  end
endmodule // tb
